//--- logic/csse_defs.vh
`ifndef CSSE_DEFS_VH
`define CSSE_DEFS_VH

// register byte offsets
`define CSSE_OFF_CTRL        5'h00
`define CSSE_OFF_STATUS      5'h04
`define CSSE_OFF_EVENT       5'h08
`define CSSE_OFF_MASK        5'h0c

// control register fields, socket index added to the lsb, times the stride for enables
`define CSSE_CTRL_IO_LSB     0
`define CSSE_CTRL_DMA_LSB    2
`define CSSE_CTRL_RING_LSB   4
`define CSSE_CTRL_EN_LSB     8
`define CSSE_CTRL_EN_STRIDE  4
`define CSSE_CTRL_RESET      32'h00000000

// status register fields within one socket byte
`define CSSE_ST_STRIDE       8
`define CSSE_ST_SENSE1       0
`define CSSE_ST_SENSE2       1
`define CSSE_ST_PRESENT      2
`define CSSE_ST_PARTIAL      3
`define CSSE_ST_BATT_LSB     4
`define CSSE_ST_CHANGE       6
`define CSSE_ST_AUDIO        7

// event and mask fields within one socket nibble
`define CSSE_EV_STRIDE       4
`define CSSE_EV_DETECT       0
`define CSSE_EV_BATTERY_SENSE_ONE         1
`define CSSE_EV_WARN         2
`define CSSE_EV_RESET        8'h00
`define CSSE_MASK_RESET      8'h00

// battery condition codes
`define CSSE_BATT_GOOD       2'h0
`define CSSE_BATT_WEAK       2'h1
`define CSSE_BATT_DEAD       2'h2

// synchroniser depth and idle level of card lines
`define CSSE_SYNC_DEPTH      2
`define CSSE_PIN_IDLE        8'hff

`endif

//--- logic/csse_sync.v
`include "csse_defs.vh"

module csse_sync
#(
	parameter WIDTH = 8,
	parameter DEPTH = `CSSE_SYNC_DEPTH
)
(
	// clock and reset
	input  wire             i_clk,
	input  wire             i_reset,
	// asynchronous lines and their synchronised copy
	input  wire [WIDTH-1:0] i_async,
	output wire [WIDTH-1:0] o_sync
);

	reg [WIDTH*DEPTH-1:0] stage_reg;

	// idle level on reset so no false event fires at release
	always @(posedge i_clk)
	begin
		if (i_reset)
			stage_reg <= {DEPTH{`CSSE_PIN_IDLE}};
		else
			stage_reg <= {stage_reg[WIDTH*(DEPTH-1)-1:0], i_async};
	end

	assign o_sync = stage_reg[WIDTH*DEPTH-1 -: WIDTH];

endmodule

//--- logic/csse_top.v
// Local design decisions: register access over Avalon-MM and the address map.
`include "csse_defs.vh"

module csse_top
#(
	parameter SOCKETS = 2
)
(
	// clock and reset
	input  wire                 i_clk,
	input  wire                 i_reset,
	// avalon-mm slave
	input  wire [4:0]           i_avs_address,
	input  wire                 i_avs_read,
	input  wire                 i_avs_write,
	input  wire [31:0]          i_avs_writedata,
	input  wire [3:0]           i_avs_byteenable,
	output reg  [31:0]          o_avs_readdata,
	output reg                  o_avs_waitrequest,
	// interrupt
	output reg                  o_irq,
	// card sense lines, one bit per socket
	input  wire [SOCKETS-1:0]   i_battery_sense_one,
	input  wire [SOCKETS-1:0]   i_battery_sense_two,
	input  wire [SOCKETS-1:0]   i_insert_sense_one_n,
	input  wire [SOCKETS-1:0]   i_insert_sense_two_n,
	// host card cycle request, one bit per socket
	input  wire [SOCKETS-1:0]   i_cycle_active,
	input  wire [SOCKETS-1:0]   i_cycle_addr0,
	input  wire [SOCKETS-1:0]   i_cycle_wide,
	// card enables, active low
	output reg  [SOCKETS-1:0]   o_byte_select_even_n,
	output reg  [SOCKETS-1:0]   o_byte_select_odd_n,
	// alternate line functions
	output reg                  o_combined_audio_out,
	output reg  [SOCKETS-1:0]   o_modem_call_alert,
	output reg  [SOCKETS-1:0]   o_card_status_change,
	output reg  [SOCKETS-1:0]   o_dma_request
);

	function [1:0] batt_decode;
		input sense_one;
		input sense_two;
		begin
			if (!sense_one)
				batt_decode = `CSSE_BATT_DEAD;
			else if (!sense_two)
				batt_decode = `CSSE_BATT_WEAK;
			else
				batt_decode = `CSSE_BATT_GOOD;
		end
	endfunction

	function [31:0] lane_merge;
		input [31:0] old_val;
		input [31:0] new_val;
		input [3:0]  lanes;
		integer k;
		begin
			lane_merge = old_val;
			for (k = 0; k < 4; k = k + 1)
				if (lanes[k])
					lane_merge[k*8 +: 8] = new_val[k*8 +: 8];
		end
	endfunction

	// true in the cycle a condition first holds
	function became;
		input now_val;
		input was_val;
		begin
			became = now_val & ~was_val;
		end
	endfunction

	reg  [31:0]          ctrl_reg;
	reg  [7:0]           event_reg;
	reg  [7:0]           event_next;
	reg  [7:0]           mask_reg;
	reg  [31:0]          rdata_next;
	wire [15:0]          status_word;
	wire [7:0]           event_set;
	wire [SOCKETS-1:0]   audio_bit;
	wire [SOCKETS-1:0]   change_lvl;
	wire [SOCKETS-1:0]   dma_lvl;
	wire [4*SOCKETS-1:0] card_sync;
	wire                 bus_req;
	wire                 bus_take;
	wire                 wr_take;
	wire                 rd_take;
	wire                 event_clear;

	localparam BUS_WAIT   = 1'b0;
	localparam BUS_ANSWER = 1'b1;

	reg                  bus_state_reg;
	reg                  bus_state_next;

	// all card lines cross into the clock domain before anything reads them
	csse_sync
	#(
		.WIDTH (4*SOCKETS),
		.DEPTH (`CSSE_SYNC_DEPTH)
	)
	u_sync
	(
		.i_clk   (i_clk),
		.i_reset (i_reset),
		.i_async ({i_insert_sense_two_n, i_insert_sense_one_n,
		           i_battery_sense_two, i_battery_sense_one}),
		.o_sync  (card_sync)
	);

	genvar s;
	generate
		for (s = 0; s < SOCKETS; s = s + 1)
		begin : g_sock
			wire       b1;
			wire       b2;
			wire       c1_n;
			wire       c2_n;
			wire       io_mode;
			wire       dma_en;
			wire [2:0] enables;
			wire       present;
			wire       partial;
			wire [1:0] batt;
			wire       change;
			reg        present_prev_reg;
			reg  [1:0] batt_prev_reg;
			reg        change_prev_reg;

			assign b1      = card_sync[s];
			assign b2      = card_sync[SOCKETS + s];
			assign c1_n    = card_sync[2*SOCKETS + s];
			assign c2_n    = card_sync[3*SOCKETS + s];
			assign io_mode = ctrl_reg[`CSSE_CTRL_IO_LSB + s];
			assign dma_en  = ctrl_reg[`CSSE_CTRL_DMA_LSB + s];
			assign enables = ctrl_reg[`CSSE_CTRL_EN_LSB + s*`CSSE_CTRL_EN_STRIDE +: 3];

			// grounded detect pins on the card pull both lines low
			assign present = ~c1_n & ~c2_n;
			assign partial = c1_n ^ c2_n;

			// battery meaning only applies to memory cards
			assign batt    = io_mode ? `CSSE_BATT_GOOD : batt_decode(b1, b2);
			// status change pin is active low from an io card
			assign change  = io_mode & present & ~b1;

			// line two is either audio or dma request, never both
			assign audio_bit[s]  = io_mode & ~dma_en & present & b2;
			assign dma_lvl[s]    = io_mode & dma_en & present & b2;
			assign change_lvl[s] = change;

			assign status_word[s*`CSSE_ST_STRIDE + `CSSE_ST_SENSE1]  = ~c1_n;
			assign status_word[s*`CSSE_ST_STRIDE + `CSSE_ST_SENSE2]  = ~c2_n;
			assign status_word[s*`CSSE_ST_STRIDE + `CSSE_ST_PRESENT] = present;
			assign status_word[s*`CSSE_ST_STRIDE + `CSSE_ST_PARTIAL] = partial;
			assign status_word[s*`CSSE_ST_STRIDE + `CSSE_ST_BATT_LSB +: 2] = batt;
			assign status_word[s*`CSSE_ST_STRIDE + `CSSE_ST_CHANGE]  = change;
			assign status_word[s*`CSSE_ST_STRIDE + `CSSE_ST_AUDIO]   = audio_bit[s];

			always @(posedge i_clk)
			begin
				if (i_reset)
				begin
					present_prev_reg <= 1'b0;
					batt_prev_reg    <= `CSSE_BATT_GOOD;
					change_prev_reg  <= 1'b0;
				end
				else
				begin
					present_prev_reg <= present;
					batt_prev_reg    <= batt;
					change_prev_reg  <= change;
				end
			end

			// events fire only for conditions software enabled
			assign event_set[s*`CSSE_EV_STRIDE + `CSSE_EV_DETECT] =
				enables[`CSSE_EV_DETECT] & (present ^ present_prev_reg);
			assign event_set[s*`CSSE_EV_STRIDE + `CSSE_EV_BATTERY_SENSE_ONE] =
				enables[`CSSE_EV_BATTERY_SENSE_ONE] &
				(became(change, change_prev_reg) |
				 became(batt == `CSSE_BATT_DEAD, batt_prev_reg == `CSSE_BATT_DEAD));
			assign event_set[s*`CSSE_EV_STRIDE + `CSSE_EV_WARN] =
				enables[`CSSE_EV_WARN] &
				became(batt == `CSSE_BATT_WEAK, batt_prev_reg == `CSSE_BATT_WEAK);
			assign event_set[s*`CSSE_EV_STRIDE + 3] = 1'b0;
		end
	endgenerate

	// each access takes one wait cycle; the answer stands for one cycle
	assign bus_req     = i_avs_read | i_avs_write;
	assign bus_take    = bus_req & ~o_avs_waitrequest;
	assign wr_take     = i_avs_write & bus_take;
	assign rd_take     = i_avs_read & bus_take;
	assign event_clear = rd_take & (i_avs_address == `CSSE_OFF_EVENT);

	always @*
	begin
		rdata_next = 32'h00000000;
		case (i_avs_address)
			`CSSE_OFF_CTRL:   rdata_next = ctrl_reg;
			`CSSE_OFF_STATUS: rdata_next = {16'h0000, status_word};
			`CSSE_OFF_EVENT:  rdata_next = {24'h000000, event_reg};
			`CSSE_OFF_MASK:   rdata_next = {24'h000000, mask_reg};
			default:          rdata_next = 32'h00000000;
		endcase
	end

	// a read clears only the bits it reported, so an event that lands
	// after the read data were captured is kept for the next read
	always @*
	begin
		event_next = event_reg;
		if (event_clear)
			event_next = event_reg & ~o_avs_readdata[7:0];
		event_next = event_next | event_set;
	end

	// the answer state lasts one cycle whatever the master does next
	always @*
	begin
		bus_state_next = bus_state_reg;
		case (bus_state_reg)
			BUS_WAIT:
			begin
				if (bus_req)
					bus_state_next = BUS_ANSWER;
			end
			BUS_ANSWER:
				bus_state_next = BUS_WAIT;
			default:
				bus_state_next = BUS_WAIT;
		endcase
	end

	always @(posedge i_clk)
	begin
		if (i_reset)
		begin
			bus_state_reg     <= BUS_WAIT;
			o_avs_waitrequest <= 1'b1;
			o_avs_readdata    <= 32'h00000000;
		end
		else
		begin
			bus_state_reg     <= bus_state_next;
			o_avs_waitrequest <= (bus_state_next != BUS_ANSWER);
			if (i_avs_read && bus_state_reg == BUS_WAIT)
				o_avs_readdata <= rdata_next;
		end
	end

	always @(posedge i_clk)
	begin
		if (i_reset)
		begin
			ctrl_reg <= `CSSE_CTRL_RESET;
			mask_reg <= `CSSE_MASK_RESET;
		end
		else
		begin
			if (wr_take && i_avs_address == `CSSE_OFF_CTRL)
				ctrl_reg <= lane_merge(ctrl_reg, i_avs_writedata, i_avs_byteenable);
			if (wr_take && i_avs_address == `CSSE_OFF_MASK && i_avs_byteenable[0])
				mask_reg <= i_avs_writedata[7:0];
		end
	end

	// the interrupt follows the next event value so it leaves a flip-flop
	always @(posedge i_clk)
	begin
		if (i_reset)
		begin
			event_reg <= `CSSE_EV_RESET;
			o_irq     <= 1'b0;
		end
		else
		begin
			event_reg <= event_next;
			o_irq     <= |(event_next & mask_reg);
		end
	end

	// byte lane enables, all registered
	integer p;
	always @(posedge i_clk)
	begin
		if (i_reset)
		begin
			o_byte_select_even_n <= {SOCKETS{1'b1}};
			o_byte_select_odd_n  <= {SOCKETS{1'b1}};
		end
		else
		begin
			for (p = 0; p < SOCKETS; p = p + 1)
			begin
				// a wide cycle opens both byte lanes at once
				o_byte_select_even_n[p] <=
					~(i_cycle_active[p] & (i_cycle_wide[p] | ~i_cycle_addr0[p]));
				o_byte_select_odd_n[p]  <=
					~(i_cycle_active[p] & (i_cycle_wide[p] | i_cycle_addr0[p]));
			end
		end
	end

	// alternate functions of the battery lines, all registered
	integer r;
	always @(posedge i_clk)
	begin
		if (i_reset)
		begin
			o_modem_call_alert   <= {SOCKETS{1'b0}};
			o_card_status_change <= {SOCKETS{1'b0}};
			o_dma_request        <= {SOCKETS{1'b0}};
		end
		else
		begin
			for (r = 0; r < SOCKETS; r = r + 1)
			begin
				// modem cards reuse the change line as ring
				o_modem_call_alert[r]   <= change_lvl[r] &
					ctrl_reg[`CSSE_CTRL_RING_LSB + r];
				o_card_status_change[r] <= change_lvl[r] &
					~ctrl_reg[`CSSE_CTRL_RING_LSB + r];
				o_dma_request[r]        <= dma_lvl[r];
			end
		end
	end

	// exclusive or keeps two tones audible as a mix
	always @(posedge i_clk)
	begin
		if (i_reset)
			o_combined_audio_out <= 1'b0;
		else
			o_combined_audio_out <= ^audio_bit;
	end

endmodule

//--- bench/csse_card_model.sv
module csse_card_model
(
	// commands from the bench, one bit per socket
	input  wire logic [1:0] i_inserted,
	input  wire logic [1:0] i_half,
	input  wire logic [1:0] i_line_one,
	input  wire logic [1:0] i_line_two,
	// socket pins
	output wire logic [1:0] o_battery_sense_one,
	output wire logic [1:0] o_battery_sense_two,
	output wire logic [1:0] o_insert_sense_one_n,
	output wire logic [1:0] o_insert_sense_two_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// detect lines are grounded inside the card; an empty socket floats to the pull-up
	assign o_insert_sense_one_n = ~(i_inserted | i_half);
	assign o_insert_sense_two_n = ~i_inserted;
	// high means good battery; line one doubles as ring, line two as dma request
	assign o_battery_sense_one = i_line_one | ~i_inserted;
	assign o_battery_sense_two = i_line_two | ~i_inserted;
endmodule

//--- bench/csse_top_props.sv
module csse_top_props
#(
	parameter SOCKETS = 2
)
(
	input wire logic               i_clk,
	input wire logic               i_reset,
	input wire logic [4:0]         i_avs_address,
	input wire logic               i_avs_read,
	input wire logic               i_avs_write,
	input wire logic [31:0]        o_avs_readdata,
	input wire logic               o_avs_waitrequest,
	input wire logic [SOCKETS-1:0] i_battery_sense_one,
	input wire logic [SOCKETS-1:0] i_battery_sense_two,
	input wire logic [SOCKETS-1:0] i_insert_sense_one_n,
	input wire logic [SOCKETS-1:0] i_insert_sense_two_n,
	input wire logic [SOCKETS-1:0] i_cycle_active,
	input wire logic [SOCKETS-1:0] i_cycle_addr0,
	input wire logic [SOCKETS-1:0] i_cycle_wide,
	input wire logic [SOCKETS-1:0] o_byte_select_even_n,
	input wire logic [SOCKETS-1:0] o_byte_select_odd_n,
	input wire logic [SOCKETS-1:0] o_modem_call_alert,
	input wire logic [SOCKETS-1:0] o_card_status_change,
	input wire logic [SOCKETS-1:0] o_dma_request
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);
	AST_EVEN: assert property (i_cycle_active[0] && !i_cycle_addr0[0] && !i_cycle_wide[0]
		|=> !o_byte_select_even_n[0] && o_byte_select_odd_n[0]) else $error("even select wrong");
	AST_ODD: assert property (i_cycle_active[1] && i_cycle_addr0[1] && !i_cycle_wide[1]
		|=> o_byte_select_even_n[1] && !o_byte_select_odd_n[1]) else $error("odd select wrong");
	AST_IDLE: assert property (!i_cycle_active[0]
		|=> o_byte_select_even_n[0] && o_byte_select_odd_n[0]) else $error("select without cycle");
	AST_WAIT: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
		|=> !o_avs_waitrequest) else $error("no answer after one wait");
	AST_STAND: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
		else $error("waitrequest low too long");
	AST_UNMAP: assert property (i_avs_read && !o_avs_waitrequest && i_avs_address[4]
		|-> o_avs_readdata == 32'h0) else $error("unmapped read not zero");
	AST_DMA: assert property (o_dma_request[0] |-> $past(i_battery_sense_two[0], 3)
		&& !$past(i_insert_sense_one_n[0], 3) && !$past(i_insert_sense_two_n[0], 3))
		else $error("dma wrong");
	AST_CHG: assert property (o_card_status_change[0] |-> !$past(i_battery_sense_one[0], 3))
		else $error("status change without line");
	AST_RING: assert property (o_modem_call_alert[0] |-> !$past(i_battery_sense_one[0], 3))
		else $error("ring without line");
endmodule

bind csse_top csse_top_props #(.SOCKETS(SOCKETS)) u_csse_props (.i_clk(i_clk),
	.i_reset(i_reset), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
	.i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
	.o_avs_waitrequest(o_avs_waitrequest), .i_battery_sense_one(i_battery_sense_one),
	.i_battery_sense_two(i_battery_sense_two), .i_insert_sense_one_n(i_insert_sense_one_n),
	.i_insert_sense_two_n(i_insert_sense_two_n), .i_cycle_active(i_cycle_active),
	.i_cycle_addr0(i_cycle_addr0), .i_cycle_wide(i_cycle_wide),
	.o_byte_select_even_n(o_byte_select_even_n), .o_byte_select_odd_n(o_byte_select_odd_n),
	.o_modem_call_alert(o_modem_call_alert), .o_card_status_change(o_card_status_change),
	.o_dma_request(o_dma_request));

//--- bench/test_card_socket_status_enables.sv
module test_card_socket_status_enables;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_clk, i_reset, i_avs_read, i_avs_write, wait_req, irq, audio;
	logic [4:0]  i_avs_address;
	logic [31:0] i_avs_writedata, rdata, q;
	logic [1:0]  act, a0, wide, ins, half, l1, l2, s1, s2, d1, d2, ev_n, od_n, alert, chg, dma;
	int          miscompares, checked;

	csse_top i_csse_top (.i_clk(i_clk), .i_reset(i_reset), .i_avs_address(i_avs_address),
		.i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
		.i_avs_byteenable(4'hf), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req), .o_irq(irq),
		.i_battery_sense_one(s1), .i_battery_sense_two(s2), .i_insert_sense_one_n(d1),
		.i_insert_sense_two_n(d2), .i_cycle_active(act), .i_cycle_addr0(a0), .i_cycle_wide(wide),
		.o_byte_select_even_n(ev_n), .o_byte_select_odd_n(od_n), .o_combined_audio_out(audio),
		.o_modem_call_alert(alert), .o_card_status_change(chg), .o_dma_request(dma));
	csse_card_model i_csse_card_model (.i_inserted(ins), .i_half(half), .i_line_one(l1),
		.i_line_two(l2), .o_battery_sense_one(s1), .o_battery_sense_two(s2),
		.o_insert_sense_one_n(d1), .o_insert_sense_two_n(d2));

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e)
		begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask

	// holds the request until waitrequest is sampled low, then idles one edge
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		i_avs_address <= a;
		i_avs_writedata <= d;
		i_avs_read <= !w;
		i_avs_write <= w;
		do
		begin
			@(posedge i_clk);
		end
		while (wait_req !== 1'b0);
		q = rdata;
		chk(wait_req, 0);
		i_avs_read <= 1'b0;
		i_avs_write <= 1'b0;
		@(posedge i_clk);
	endtask

	// card lines need two sync stages plus an output register before they show
	task automatic wt;
		repeat (5) @(posedge i_clk);
	endtask

	task automatic t_regs;
		bus(0, 5'h00, 0);
		chk(q, 32'h0);
		bus(1, 5'h00, 32'h773f);
		bus(1, 5'h10, 32'hffff);
		bus(0, 5'h00, 0);
		chk(q, 32'h773f);
		bus(0, 5'h14, 0);
		chk(q, 32'h0);
		bus(1, 5'h0c, 32'h77);
		bus(0, 5'h0c, 0);
		chk(q, 32'h77);
		bus(1, 5'h0c, 0);
		bus(1, 5'h00, 0);
	endtask

	// socket A steps good, dead, dead, weak, good with dead and weak events enabled
	task automatic t_batt;
		logic [1:0] bt;
		bus(1, 5'h00, 32'h600);
		bus(0, 5'h08, 0);
		for (int i = 0; i < 4; i++)
		begin
			l1 <= {1'b1, i[1]};
			l2 <= {1'b1, i[0]};
			bt = !i[1] ? 2'h2 : (!i[0] ? 2'h1 : 2'h0);
			wt;
			bus(0, 5'h04, 0);
			chk(q & 32'h3f, {26'h0, bt, 4'h7});
		end
		bus(0, 5'h08, 0);
		chk(q, 32'h6);
		bus(1, 5'h00, 0);
	endtask

	task automatic t_det;
		bus(1, 5'h00, 32'h100);
		bus(1, 5'h0c, 32'h1);
		bus(0, 5'h08, 0);
		ins <= 2'b00;
		half <= 2'b01;
		wt;
		bus(0, 5'h04, 0);
		chk(q & 32'hc, 32'h8);
		ins <= 2'b01;
		half <= 2'b00;
		wt;
		chk(irq, 1);
		bus(0, 5'h04, 0);
		chk(q & 32'hc, 32'h4);
		bus(0, 5'h08, 0);
		chk(q & 32'h1, 32'h1);
		wt;
		chk(irq, 0);
		bus(1, 5'h00, 0);
		ins <= 2'b00;
		wt;
		bus(0, 5'h08, 0);
		chk(q & 32'h1, 32'h0);
		ins <= 2'b11;
		wt;
	endtask

	task automatic t_io;
		bus(1, 5'h00, 32'h3);
		l1 <= 2'b10;
		wt;
		chk({chg[0], alert[0]}, 2'b10);
		bus(1, 5'h00, 32'h13);
		wt;
		chk({chg[0], alert[0]}, 2'b01);
		l1 <= 2'b11;
		l2 <= 2'b01;
		wt;
		chk(audio, 1);
		l2 <= 2'b11;
		wt;
		chk(audio, 0);
		bus(1, 5'h00, 32'h0);
		l2 <= 2'b01;
		wt;
		chk(audio, 0);
		bus(1, 5'h00, 32'h5);
		wt;
		chk({dma[0], audio}, 2'b10);
		l2 <= 2'b10;
		wt;
		chk(dma[0], 0);
		l2 <= 2'b11;
		bus(1, 5'h00, 32'h0);
	endtask

	task automatic t_ce;
		for (int i = 0; i < 8; i++)
		begin
			act <= {2{i[2]}};
			a0 <= {2{i[1]}};
			wide <= {2{i[0]}};
			repeat (2) @(posedge i_clk);
			chk({ev_n, od_n}, {{2{!(i[2] & (i[0] | !i[1]))}}, {2{!(i[2] & (i[0] | i[1]))}}});
		end
	endtask

	task automatic end_of_test;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial
	begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end

	// whole sequence needs well under a thousand cycles
	initial
	begin
		#40000;
		miscompares++;
		end_of_test;
	end

	initial
	begin
		i_reset <= 1'b1;
		{i_avs_read, i_avs_write, i_avs_address, i_avs_writedata} <= 39'h0;
		{act, a0, wide, half} <= 8'h00;
		// socket A holds a memory card with a good battery, socket B is empty
		ins <= 2'b01;
		{l1, l2} <= 4'hf;
		repeat (4) @(posedge i_clk);
		i_reset <= 1'b0;
		@(posedge i_clk);
		t_regs;
		t_batt;
		t_det;
		t_io;
		t_ce;
		end_of_test;
	end
endmodule
